// [rtl/qsp_port.sv]
// burst sram port: double rate write and read ports over one address bus
`timescale 1ns/1ps
`default_nettype none
// Function
// - a write starts when write select is low and read select high at a k rise, its four words follow on k and kN rises of cycles t+1 and t+2.
// - a read taken at cycle t drives its words on the output clock edges cN(t+1), c(t+2), cN(t+2), c(t+3).
// - a burst covers the latched address and the next three sequential addresses, first word first.
// - cycle t is the cycle whose k rise starts the access, t+1 to t+3 are the three that follow.
// - after power-up both ports are deselected and the read outputs are not driven.
// - write data is taken on the rises of both k and kN.
// - read data is launched on the output clock pair, or on the input pair in single clock mode.
// - with both lane selects low at a data edge the whole word is stored.
// - with only lane 0 low only the lower part is stored and the upper part kept.
// - with only lane 1 low only the upper part is stored and the lower part kept.
// - with both lane selects high nothing is stored for that beat, selects being taken per edge.
// - a read right after a read, or a write right after a write, is ignored.
// - with both selects low the read wins after idle or a write, the write wins after a read.
module qsp_port
	import qsp_pkg::*;
#(
	parameter int DATA_W = QSP_DATA_W,
	parameter int LO_W   = QSP_LO_W,
	parameter int ADDR_W = QSP_ADDR_W
) (
	input  wire logic              clk_sys,
	input  wire logic              rst_b,
	input  wire qsp_clk_t          pinClk,
	input  wire qsp_sel_t          portSel,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] wrData,
	input  wire logic [1:0]        byteWriteSelectN,
	output logic      [DATA_W-1:0] rdData,
	output logic                   rdDataOe,
	output logic                   singleClkMode
);
	// ----------------------------------------------------------------
	// clock pin edges
	// ----------------------------------------------------------------
	logic [3:0] rise;
	logic       kRise;
	logic       kNRise;
	logic       oPRise;
	logic       oNRise;

	// no pin edge means no state change, except the strap sampled in the first cycle after reset
	qsp_rise_det #(.W(4)) u_rise (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.level   (pinClk),
		.rise    (rise)
	);

	// ----------------------------------------------------------------
	// strap and arbitration state
	// ----------------------------------------------------------------
	logic              strapDone_r;
	logic              strapDone_nxt;
	logic              singleClk_r;
	logic              singleClk_nxt;
	logic              prevRd_r;
	logic              prevRd_nxt;
	logic              prevWr_r;
	logic              prevWr_nxt;
	logic              rdGo;
	logic              wrGo;

	always_comb
	begin
		kRise         = rise[3];
		kNRise        = rise[2];
		oPRise        = singleClk_r ? rise[3] : rise[1];
		oNRise        = singleClk_r ? rise[2] : rise[0];
		strapDone_nxt = 1'b1;
		singleClk_nxt = singleClk_r;
		if (!strapDone_r)
			singleClk_nxt = pinClk.c & pinClk.cN;
		// read first unless the previous k rise started a read
		rdGo = kRise & ~portSel.readPortSelectN & ~prevRd_r;
		wrGo = kRise & ~portSel.writePortSelectN & ~prevWr_r & ~rdGo;
		prevRd_nxt = kRise ? rdGo : prevRd_r;
		prevWr_nxt = kRise ? wrGo : prevWr_r;
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			strapDone_r <= 1'b0;
			singleClk_r <= 1'b0;
			prevRd_r    <= 1'b0;
			prevWr_r    <= 1'b0;
		end
		else
		begin
			strapDone_r <= strapDone_nxt;
			singleClk_r <= singleClk_nxt;
			prevRd_r    <= prevRd_nxt;
			prevWr_r    <= prevWr_nxt;
		end
	end

	// ----------------------------------------------------------------
	// storage array
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

	// ----------------------------------------------------------------
	// write port
	// ----------------------------------------------------------------
	logic              wrAct_r;
	logic              wrAct_nxt;
	logic [1:0]        wrBeat_r;
	logic [1:0]        wrBeat_nxt;
	logic [ADDR_W-1:0] wrAddr_r;
	logic [ADDR_W-1:0] wrAddr_nxt;
	logic              wrPend_r;
	logic              wrPend_nxt;
	logic [ADDR_W-1:0] wrPendAddr_r;
	logic [ADDR_W-1:0] wrPendAddr_nxt;
	logic              wrBeatEdge;
	logic [ADDR_W-1:0] wrBeatAddr;

	always_comb
	begin
		wrAct_nxt      = wrAct_r;
		wrBeat_nxt     = wrBeat_r;
		wrAddr_nxt     = wrAddr_r;
		wrPend_nxt     = wrPend_r;
		wrPendAddr_nxt = wrPendAddr_r;
		// even beats on k, odd beats on kN; the kN of cycle t is skipped
		wrBeatEdge     = wrAct_r & (wrBeat_r[0] ? kNRise : kRise);
		wrBeatAddr     = wrAddr_r + ADDR_W'(wrBeat_r);
		if (wrBeatEdge)
		begin
			wrBeat_nxt = wrBeat_r + QSP_BEAT_STEP;
			if (wrBeat_r == QSP_LAST_BEAT)
				wrAct_nxt = 1'b0;
		end
		// promote at kN(t), the old burst may end on that same edge
		if (kNRise && wrPend_r && (!wrAct_r || (wrBeatEdge && wrBeat_r == QSP_LAST_BEAT)))
		begin
			wrAct_nxt  = 1'b1;
			wrBeat_nxt = 2'h0;
			wrAddr_nxt = wrPendAddr_r;
			wrPend_nxt = 1'b0;
		end
		if (wrGo)
		begin
			wrPend_nxt     = 1'b1;
			wrPendAddr_nxt = addr;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wrAct_r      <= 1'b0;
			wrBeat_r     <= 2'h0;
			wrAddr_r     <= '0;
			wrPend_r     <= 1'b0;
			wrPendAddr_r <= '0;
		end
		else
		begin
			wrAct_r      <= wrAct_nxt;
			wrBeat_r     <= wrBeat_nxt;
			wrAddr_r     <= wrAddr_nxt;
			wrPend_r     <= wrPend_nxt;
			wrPendAddr_r <= wrPendAddr_nxt;
		end
	end

	// array has no reset; lanes are judged on every data edge
	always_ff @(posedge clk_sys)
	begin
		if (wrBeatEdge)
		begin
			if (!byteWriteSelectN[QSP_LANE_LO])
				mem[wrBeatAddr][LO_W-1:0] <= wrData[LO_W-1:0];
			if (!byteWriteSelectN[QSP_LANE_HI])
				mem[wrBeatAddr][DATA_W-1:LO_W] <= wrData[DATA_W-1:LO_W];
		end
	end

	// ----------------------------------------------------------------
	// read port
	// ----------------------------------------------------------------
	qsp_rd_state_t     rdState_r;
	qsp_rd_state_t     rdState_nxt;
	logic [1:0]        rdBeat_r;
	logic [1:0]        rdBeat_nxt;
	logic [ADDR_W-1:0] rdAddr_r;
	logic [ADDR_W-1:0] rdAddr_nxt;
	logic              rdPend_r;
	logic              rdPend_nxt;
	logic              rdArm_r;
	logic              rdArm_nxt;
	logic [ADDR_W-1:0] rdPendAddr_r;
	logic [ADDR_W-1:0] rdPendAddr_nxt;
	logic [DATA_W-1:0] rdData_r;
	logic [DATA_W-1:0] rdData_nxt;
	logic              rdOe_r;
	logic              rdOe_nxt;
	logic              rdReady;
	logic              rdBeatEdge;

	always_comb
	begin
		rdState_nxt    = rdState_r;
		rdBeat_nxt     = rdBeat_r;
		rdAddr_nxt     = rdAddr_r;
		rdPend_nxt     = rdPend_r;
		rdArm_nxt      = rdArm_r | (kRise & rdPend_r);
		rdPendAddr_nxt = rdPendAddr_r;
		rdData_nxt     = rdData_r;
		rdOe_nxt       = rdOe_r;
		// a pending read may go only once k(t+1) has risen
		rdReady        = rdPend_r & (rdArm_r | kRise);
		rdBeatEdge     = rdBeat_r[0] ? oPRise : oNRise;
		case (rdState_r)
			QSP_RD_IDLE, QSP_RD_DRAIN:
			begin
				if (oNRise && rdReady)
				begin
					rdData_nxt  = mem[rdPendAddr_r];
					rdOe_nxt    = 1'b1;
					rdAddr_nxt  = rdPendAddr_r;
					rdBeat_nxt  = QSP_BEAT_STEP;
					rdPend_nxt  = 1'b0;
					rdArm_nxt   = 1'b0;
					rdState_nxt = QSP_RD_BURST;
				end
				else if (rdState_r == QSP_RD_DRAIN && oPRise)
				begin
					rdOe_nxt    = 1'b0;
					rdState_nxt = QSP_RD_IDLE;
				end
			end
			QSP_RD_BURST:
			begin
				if (rdBeatEdge)
				begin
					rdData_nxt = mem[rdAddr_r + ADDR_W'(rdBeat_r)];
					rdBeat_nxt = rdBeat_r + QSP_BEAT_STEP;
					if (rdBeat_r == QSP_LAST_BEAT)
					begin
						// back to back reads keep the bus driven without a gap
						if (rdReady)
						begin
							rdAddr_nxt = rdPendAddr_r;
							rdBeat_nxt = 2'h0;
							rdPend_nxt = 1'b0;
							rdArm_nxt  = 1'b0;
						end
						else
							rdState_nxt = QSP_RD_DRAIN;
					end
				end
			end
			default:
			begin
				rdState_nxt = QSP_RD_IDLE;
				rdOe_nxt    = QSP_OE_RST;
			end
		endcase
		if (rdGo)
		begin
			rdPend_nxt     = 1'b1;
			rdArm_nxt      = 1'b0;
			rdPendAddr_nxt = addr;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rdState_r    <= QSP_RD_IDLE;
			rdBeat_r     <= 2'h0;
			rdAddr_r     <= '0;
			rdPend_r     <= 1'b0;
			rdArm_r      <= 1'b0;
			rdPendAddr_r <= '0;
			rdData_r     <= '0;
			rdOe_r       <= QSP_OE_RST;
		end
		else
		begin
			rdState_r    <= rdState_nxt;
			rdBeat_r     <= rdBeat_nxt;
			rdAddr_r     <= rdAddr_nxt;
			rdPend_r     <= rdPend_nxt;
			rdArm_r      <= rdArm_nxt;
			rdPendAddr_r <= rdPendAddr_nxt;
			rdData_r     <= rdData_nxt;
			rdOe_r       <= rdOe_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	always_comb
	begin
		rdData        = rdData_r;
		rdDataOe      = rdOe_r;
		singleClkMode = singleClk_r;
	end
endmodule : qsp_port
`default_nettype wire

// [rtl/qsp_pkg.sv]
// shared constants and types of the burst sram port block
package qsp_pkg;
	// ----------------------------------------------------------------
	// widths and counts
	// ----------------------------------------------------------------
	localparam int          QSP_DATA_W    = 18;
	localparam int          QSP_LO_W      = 9;
	localparam int          QSP_ADDR_W    = 10;
	localparam int          QSP_LANE_LO   = 0;
	localparam int          QSP_LANE_HI   = 1;
	localparam logic [1:0]  QSP_LAST_BEAT = 2'h3;
	localparam logic [1:0]  QSP_BEAT_STEP = 2'h1;
	localparam logic        QSP_OE_RST    = 1'h0;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic k;
		logic kN;
		logic c;
		logic cN;
	} qsp_clk_t;

	typedef struct packed {
		logic readPortSelectN;
		logic writePortSelectN;
	} qsp_sel_t;

	typedef enum logic [1:0] {
		QSP_RD_IDLE  = 2'b00,
		QSP_RD_BURST = 2'b01,
		QSP_RD_DRAIN = 2'b10
	} qsp_rd_state_t;
endpackage : qsp_pkg

// [rtl/qsp_rise_det.sv]
// rising edge detector for a vector of sampled pin clocks
`timescale 1ns/1ps
`default_nettype none
module qsp_rise_det #(
	parameter int W = 4
) (
	input  wire logic         clk_sys,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] level,
	output logic      [W-1:0] rise
);
	logic [W-1:0] prev_r;
	logic [W-1:0] prev_nxt;

	always_comb
	begin
		prev_nxt = level;
		rise     = level & ~prev_r;
	end

	// starts high so a pin already high at reset release gives no edge
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			prev_r <= '1;
		else
			prev_r <= prev_nxt;
	end
endmodule : qsp_rise_det
`default_nettype wire

// [test/qsp_ctrl_model.sv]
// controller side model driving the clock pins
`timescale 1ns/1ps
`default_nettype none
module qsp_ctrl_model
	import qsp_pkg::*;
(
	input  wire logic  clk_sys,
	input  wire logic  rst_b,
	input  wire logic  run,
	input  wire logic  strap,
	output qsp_clk_t   pinClk,
	output logic [1:0] ph_r
);
	logic [1:0] ph_nxt;
	// a stop freezes every pin level where it is
	always_comb
	begin
		ph_nxt = ph_r + 2'(run);
	end
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			ph_r <= 2'h0;
		else
			ph_r <= ph_nxt;
	end
	// c copies k with no skew; with strap set c and cN are tied high for single clock mode
	assign pinClk = strap ? {~ph_r[1], ph_r[1], 2'b11}
		: {~ph_r[1], ph_r[1], ~ph_r[1], ph_r[1]};
endmodule : qsp_ctrl_model
`default_nettype wire

// [test/qsp_port_sva.sv]
// assertion checker for the burst sram port
`timescale 1ns/1ps
`default_nettype none
module qsp_port_sva
	import qsp_pkg::*;
#(
	parameter int DATA_W = QSP_DATA_W
) (
	input wire logic              clk_sys,
	input wire logic              rst_b,
	input wire qsp_clk_t          pinClk,
	input wire qsp_sel_t          portSel,
	input wire logic [DATA_W-1:0] rdData,
	input wire logic              rdDataOe,
	input wire logic              singleClkMode
);
	qsp_clk_t   pin_r;
	qsp_clk_t   pin2_r;
	logic [7:0] age_r;
	logic [7:0] age_nxt;
	logic       kRise;
	logic       opE;
	logic       onE;
	// edges found by sampling, as the port does
	assign kRise = pinClk.k & ~pin_r.k;
	assign opE = singleClkMode ? kRise : pinClk.c & ~pin_r.c;
	assign onE = singleClkMode ? pinClk.kN & ~pin_r.kN : pinClk.cN & ~pin_r.cN;
	always_comb
	begin
		age_nxt = (kRise && !portSel.readPortSelectN) ? 8'h00 : age_r + 8'(age_r != 8'hff);
	end
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pin_r <= qsp_clk_t'(4'hf);
			pin2_r <= qsp_clk_t'(4'hf);
			age_r <= 8'hff;
		end
		else
		begin
			pin_r <= pinClk;
			pin2_r <= pin_r;
			age_r <= age_nxt;
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	a_oe_rise_edge: assert property ($rose(rdDataOe) |-> $past(onE))
		else $error("oe rose off edge");
	a_oe_fall_edge: assert property ($fell(rdDataOe) |-> $past(opE))
		else $error("oe fell off edge");
	a_beat_on_edge: assert property (rdDataOe && $changed(rdData) |-> $past(opE || onE))
		else $error("data moved off edge");
	a_burst_holds: assert property ($rose(rdDataOe) |-> rdDataOe [*5])
		else $error("burst cut short");
	a_reset_undriven: assert property ($rose(rst_b) |-> !rdDataOe [*4])
		else $error("driven after reset");
	a_stopped_hold: assert property (pinClk == pin_r && pin_r == pin2_r
		|-> $stable(rdData) && $stable(rdDataOe))
		else $error("moved with clocks stopped");
	a_strap_fixed: assert property ($past(rst_b, 2) |-> $stable(singleClkMode))
		else $error("strap changed");
	a_oe_needs_read: assert property ($rose(rdDataOe) |-> age_r != 8'hff)
		else $error("oe without read");
	c_read: cover property ($rose(rdDataOe));
	c_end: cover property ($fell(rdDataOe));
	c_write: cover property (kRise && !portSel.writePortSelectN);
endmodule : qsp_port_sva
bind qsp_port qsp_port_sva #(.DATA_W(DATA_W)) i_sva (.clk_sys(clk_sys), .rst_b(rst_b),
	.pinClk(pinClk), .portSel(portSel), .rdData(rdData), .rdDataOe(rdDataOe),
	.singleClkMode(singleClkMode));
`default_nettype wire

// [test/testbench.sv]
// self-checking bench for the burst sram port
`timescale 1ns/1ps
`default_nettype none
module testbench
	import qsp_pkg::*;
;
	logic        clk_sys = 1'b0;
	logic        rst_b = 1'b0;
	logic        run = 1'b1;
	logic        strap = 1'b0;
	qsp_clk_t    pinClk;
	qsp_sel_t    portSel = 2'b11;
	logic [9:0]  addr = 10'h0;
	logic [17:0] wrData = 18'h0;
	logic [1:0]  byteWriteSelectN = 2'h3;
	logic [17:0] rdData;
	logic        rdDataOe;
	logic        single;
	logic [1:0]  ph;
	logic [17:0] mem [1024];
	integer      seed = 5777;
	int          fails = 0;
	int          checks_done = 0;
	always #50 clk_sys = ~clk_sys;
	qsp_ctrl_model i_ctrl (.clk_sys(clk_sys), .rst_b(rst_b), .run(run), .strap(strap),
		.pinClk(pinClk), .ph_r(ph));
	qsp_port i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .pinClk(pinClk), .portSel(portSel),
		.addr(addr), .wrData(wrData), .byteWriteSelectN(byteWriteSelectN), .rdData(rdData),
		.rdDataOe(rdDataOe), .singleClkMode(single));
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask : chk
	// bounded wait for the edge that ends phase p
	task automatic tickTo(input logic [1:0] p);
		repeat (8)
		begin
			@(posedge clk_sys);
			if (ph === p)
				return;
		end
		fails++;
		tally_and_finish();
	endtask : tickTo
	// one k period: selects and k beat land with the k rise, second beat with kN
	task automatic kper(input logic [1:0] s, input logic [9:0] a, input logic [35:0] d,
		input logic [3:0] b);
		tickTo(2'h3);
		portSel <= s;
		addr <= a;
		wrData <= d[17:0];
		byteWriteSelectN <= b[1:0];
		tickTo(2'h1);
		wrData <= d[35:18];
		byteWriteSelectN <= b[3:2];
	endtask : kper
	task automatic wr(input logic [9:0] a, input logic [71:0] d, input logic [7:0] b,
		input logic [1:0] s1);
		kper(2'b10, a, 36'h0, 4'hf);
		kper(s1, a + 10'h5, d[35:0], b[3:0]);
		kper(2'b11, a, d[71:36], b[7:4]);
		for (int i = 0; i < 4; i++)
		begin
			if (!b[2*i])
				mem[a + 10'(i)][8:0] = d[18*i +: 9];
			if (!b[2*i+1])
				mem[a + 10'(i)][17:9] = d[18*i+9 +: 9];
		end
	endtask : wr
	task automatic rd(input logic [9:0] a, input logic [1:0] s0, input logic [1:0] s1);
		kper(s0, a, 36'h0, 4'hf);
		kper(s1, a + 10'h2, 36'h0, 4'hf);
		for (int i = 0; i < 4; i++)
		begin
			repeat (i ? 2 : 1)
			begin
				@(posedge clk_sys);
				portSel <= 2'b11;
			end
			#1;
			chk({17'h0, rdDataOe}, 18'h1);
			chk(rdData, mem[a + 10'(i)]);
		end
		repeat (4) @(posedge clk_sys);
		#1;
		chk({17'h0, rdDataOe}, 18'h0);
	endtask : rd
	initial
	begin
		logic [9:0]  a;
		logic [71:0] d;
		repeat (3) @(posedge clk_sys);
		rst_b <= 1'b1;
		#1;
		chk({17'h0, rdDataOe}, 18'h0);
		for (int n = 0; n < 6; n++)
		begin
			a = n ? 10'($random(seed)) : 10'h3fe;
			d = {8'($random(seed)), 32'($random(seed)), 32'($random(seed))};
			wr(a, d, 8'h00, 2'b11);
			d = {8'($random(seed)), 32'($random(seed)), 32'($random(seed))};
			wr(a, d, n ? 8'($random(seed)) : 8'he4, 2'b11);
			rd(a, 2'b01, 2'b11);
		end
		chk({17'h0, single}, 18'h0);
		$display("test burst write and read done");
		wr(10'h105, d, 8'h00, 2'b11);
		wr(10'h100, ~d, 8'h00, 2'b10);
		rd(10'h105, 2'b00, 2'b01);
		rd(10'h100, 2'b01, 2'b11);
		$display("test back to back refusal done");
		@(posedge clk_sys);
		run <= 1'b0;
		portSel <= 2'b01;
		repeat (8) @(posedge clk_sys);
		#1;
		chk({17'h0, rdDataOe}, 18'h0);
		@(posedge clk_sys);
		portSel <= 2'b11;
		run <= 1'b1;
		$display("test stopped clocks done");
		@(posedge clk_sys);
		strap <= 1'b1;
		rst_b <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk_sys);
		#1;
		chk({17'h0, rdDataOe}, 18'h0);
		chk({17'h0, single}, 18'h1);
		d = {8'($random(seed)), 32'($random(seed)), 32'($random(seed))};
		wr(10'h2a0, d, 8'h00, 2'b11);
		rd(10'h2a0, 2'b01, 2'b11);
		$display("test single clock mode done");
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire
